/* hdl/bsd_pkg.sv */
// Constants and types shared by the burst DDR SRAM port
package bsd_pkg;

   // System clock rate
   localparam int SYS_PERIOD_NS = 10;
   localparam int SYS_MHZ       = 1000 / SYS_PERIOD_NS;

   // Lock time after a stable input clock
   localparam int LOCK_TIME_US  = 20;
   localparam int LOCK_CYC      = LOCK_TIME_US * SYS_MHZ;

   // Least input-clock stop that resets the lock, rounded up to whole cycles
   localparam int STOP_TIME_NS  = 30;
   localparam int STOP_CYC      = (STOP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   // Impedance readjust period in link clock cycles
   localparam int ZQ_PERIOD_CYC = 1024;

   // Counter widths
   localparam int LOCK_CW       = 12;
   localparam int STOP_CW       = 3;
   localparam int ZQ_CW         = 10;

   // Values after reset
   localparam logic RST_PLL_ON  = 1'b1;
   localparam logic RST_OE      = 1'b0;
   localparam logic RST_VALID   = 1'b0;

   // Lock tracker states, Gray coded along unlock -> locking -> locked
   typedef enum logic [1:0] {
      BSD_UNLOCK  = 2'b00,
      BSD_LOCKING = 2'b01,
      BSD_LOCKED  = 2'b11
   } bsd_lock_t;

endpackage : bsd_pkg

/* hdl/bsd_port.sv */
// Burst-of-two DDR SRAM device port: command, data, latency, echo and lock logic
`timescale 1ns/100ps
// Function
// - PLL on: 2.5 cycle latency, off: 1
// - Controls registered only on positive rise
// - Data captured and launched on both edges
// - Direction high, load low starts a read
// - Read words at K-bar t+2, K t+3 with PLL on, at K t+1, K-bar t+1 with PLL off
// - New read each cycle, bursts always complete
// - After reads, tristate at next negative rise with PLL on, next positive rise with PLL off
// - Direction low, load low starts a write
// - Write words at K t+1, K-bar t+1
// - New write accepted every positive rise
// - After writes finish, inputs are ignored
// - Active-low lane selects gate each byte
// - Posted write committed on next write
// - Read of just-written address is forwarded
// - Impedance readjusted every 1024 cycles
// - Two free-running echo clocks
// - Valid flag half a cycle before data
// - Lock after 20 us, stop resets lock
// - Load high is no operation, stop holds
// - Powers up deselected, outputs tristated
module bsd_port #(
   parameter int ADDR_W = 4,
   parameter int DW     = 18,
   parameter int LANES  = 2
) (
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic              clk_link,
   input  wire logic              access_load_n,
   input  wire logic              rw_read,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DW-1:0]     dq_i,
   input  wire logic [LANES-1:0]  byte_lane_select_n,
   input  wire logic              pll_bypass_n,
   output logic      [DW-1:0]     dq_o,
   output logic                   dq_oe,
   output logic                   output_valid_flag,
   output logic                   echo_timing_pos,
   output logic                   echo_timing_neg,
   output logic                   impedance_update,
   output logic                   pll_lock
);

   localparam int LW    = DW / LANES;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int WORDS = 2 * DEPTH;
   localparam int ZQ_CW = bsd_pkg::ZQ_CW;

   function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0]    old_w,
                                                 input logic [DW-1:0]    new_w,
                                                 input logic [LANES-1:0] sel_n);
      logic [DW-1:0] r;
      r = old_w;
      for (int i = 0; i < LANES; i++)
      begin
         if (!sel_n[i])
         begin
            r[i*LW +: LW] = new_w[i*LW +: LW];
         end
      end
      return r;
   endfunction : merge_lanes

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain, positive input clock rise

   logic              lrs1_ff, lrs2_ff;
   logic              bp1_ff, bp2_ff, bp3_ff, pll_on_ff;
   logic              rd_p1_ff, rd_p2_ff, wr_p1_ff, wr_p2_ff;
   logic [ADDR_W-1:0] ra1_ff, ra2_ff, wa_ff;
   logic              pw_valid_ff;
   logic [ADDR_W-1:0] pw_addr_ff;
   logic [DW-1:0]     pw_d0_ff;
   logic [LANES-1:0]  pw_m0_ff;
   logic [DW-1:0]     mem_ff [WORDS];
   logic              fetched_ff;
   logic [DW-1:0]     r0_ff, r1_ff, q_p_ff;
   logic              oe_p_ff, v_p_ff, ep_ff, zq_upd_ff;
   logic [ZQ_CW-1:0]  zq_cnt_ff;

   logic              nxt_lrs1, nxt_lrs2, nxt_bp1, nxt_bp2, nxt_bp3, nxt_pll_on;
   logic              nxt_rd_p1, nxt_rd_p2, nxt_wr_p1, nxt_wr_p2;
   logic [ADDR_W-1:0] nxt_ra1, nxt_ra2, nxt_wa;
   logic              nxt_pw_valid;
   logic [ADDR_W-1:0] nxt_pw_addr;
   logic [DW-1:0]     nxt_pw_d0;
   logic [LANES-1:0]  nxt_pw_m0;
   logic [DW-1:0]     nxt_mem [WORDS];
   logic              nxt_fetched;
   logic [DW-1:0]     nxt_r0, nxt_r1, nxt_q_p;
   logic              nxt_oe_p, nxt_v_p, nxt_ep, nxt_zq_upd;
   logic [ZQ_CW-1:0]  nxt_zq_cnt;

   // Negative-rise registers, read here
   logic [DW-1:0]     pw_d1_ff;
   logic [LANES-1:0]  pw_m1_ff;

   logic              legacy;
   logic              do_fetch;
   logic [ADDR_W-1:0] f_addr;
   logic [DW-1:0]     f_w0, f_w1;
   logic              fwd_hit;

   assign legacy   = !pll_on_ff;
   assign do_fetch = legacy ? rd_p1_ff : rd_p2_ff;
   assign f_addr   = legacy ? ra1_ff : ra2_ff;
   assign fwd_hit  = pw_valid_ff && (pw_addr_ff == f_addr);

   always_comb
   begin
      f_w0 = mem_ff[{f_addr, 1'b0}];
      f_w1 = mem_ff[{f_addr, 1'b1}];
      // Newest data lives in the posted registers until the next write
      if (fwd_hit)
      begin
         f_w0 = merge_lanes(f_w0, pw_d0_ff, pw_m0_ff);
         f_w1 = merge_lanes(f_w1, pw_d1_ff, pw_m1_ff);
      end
   end

   always_comb
   begin
      nxt_lrs1     = rstn;
      nxt_lrs2     = lrs1_ff;
      nxt_bp1      = pll_bypass_n;
      nxt_bp2      = bp1_ff;
      nxt_bp3      = bp2_ff;
      nxt_pll_on   = (bp2_ff == bp3_ff) ? bp3_ff : pll_on_ff;
      // Controls sampled only here; load high is a no-op
      nxt_rd_p1    = !access_load_n && rw_read;
      nxt_wr_p1    = !access_load_n && !rw_read;
      nxt_ra1      = nxt_rd_p1 ? addr : ra1_ff;
      nxt_wa       = nxt_wr_p1 ? addr : wa_ff;
      nxt_rd_p2    = rd_p1_ff;
      nxt_ra2      = ra1_ff;
      nxt_wr_p2    = wr_p1_ff;
      nxt_pw_valid = pw_valid_ff;
      nxt_pw_addr  = pw_addr_ff;
      nxt_pw_d0    = pw_d0_ff;
      nxt_pw_m0    = pw_m0_ff;
      nxt_mem      = mem_ff;
      // First word of a write: retire the previous posted write, then post this one
      if (wr_p1_ff)
      begin
         if (pw_valid_ff)
         begin
            nxt_mem[{pw_addr_ff, 1'b0}] = merge_lanes(mem_ff[{pw_addr_ff, 1'b0}], pw_d0_ff, pw_m0_ff);
            nxt_mem[{pw_addr_ff, 1'b1}] = merge_lanes(mem_ff[{pw_addr_ff, 1'b1}], pw_d1_ff, pw_m1_ff);
         end
         nxt_pw_valid = 1'b1;
         nxt_pw_addr  = wa_ff;
         nxt_pw_d0    = dq_i;
         nxt_pw_m0    = byte_lane_select_n;
      end
      nxt_fetched  = do_fetch;
      nxt_r0       = do_fetch ? f_w0 : r0_ff;
      nxt_r1       = do_fetch ? f_w1 : r1_ff;
      nxt_v_p      = do_fetch;
      if (legacy)
      begin
         nxt_q_p  = do_fetch ? f_w0 : q_p_ff;
         nxt_oe_p = do_fetch;
      end
      else
      begin
         nxt_q_p  = fetched_ff ? r1_ff : q_p_ff;
         nxt_oe_p = fetched_ff;
      end
      nxt_ep       = !ep_ff;
      // Free-running readjust tick
      nxt_zq_cnt   = (zq_cnt_ff == ZQ_CW'(bsd_pkg::ZQ_PERIOD_CYC - 1)) ? '0 : zq_cnt_ff + 1'b1;
      nxt_zq_upd   = (zq_cnt_ff == ZQ_CW'(bsd_pkg::ZQ_PERIOD_CYC - 1));
   end

   always_ff @(posedge clk_link)
   begin
      lrs1_ff <= nxt_lrs1;
      lrs2_ff <= nxt_lrs2;
      bp1_ff  <= nxt_bp1;
      bp2_ff  <= nxt_bp2;
      bp3_ff  <= nxt_bp3;
      mem_ff  <= nxt_mem;
      r0_ff   <= nxt_r0;
      r1_ff   <= nxt_r1;
      q_p_ff  <= nxt_q_p;
      ra1_ff  <= nxt_ra1;
      ra2_ff  <= nxt_ra2;
      wa_ff   <= nxt_wa;
      pw_addr_ff <= nxt_pw_addr;
      pw_d0_ff   <= nxt_pw_d0;
      pw_m0_ff   <= nxt_pw_m0;
      if (!lrs2_ff)
      begin
         pll_on_ff   <= bsd_pkg::RST_PLL_ON;
         rd_p1_ff    <= 1'b0;
         rd_p2_ff    <= 1'b0;
         wr_p1_ff    <= 1'b0;
         wr_p2_ff    <= 1'b0;
         pw_valid_ff <= 1'b0;
         fetched_ff  <= 1'b0;
         oe_p_ff     <= bsd_pkg::RST_OE;
         v_p_ff      <= bsd_pkg::RST_VALID;
         ep_ff       <= 1'b0;
         zq_cnt_ff   <= '0;
         zq_upd_ff   <= 1'b0;
      end
      else
      begin
         pll_on_ff   <= nxt_pll_on;
         rd_p1_ff    <= nxt_rd_p1;
         rd_p2_ff    <= nxt_rd_p2;
         wr_p1_ff    <= nxt_wr_p1;
         wr_p2_ff    <= nxt_wr_p2;
         pw_valid_ff <= nxt_pw_valid;
         fetched_ff  <= nxt_fetched;
         oe_p_ff     <= nxt_oe_p;
         v_p_ff      <= nxt_v_p;
         ep_ff       <= nxt_ep;
         zq_cnt_ff   <= nxt_zq_cnt;
         zq_upd_ff   <= nxt_zq_upd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain, negative input clock rise (falling edge of clk_link)

   logic [DW-1:0]    q_n_ff, nxt_q_n, nxt_pw_d1;
   logic [LANES-1:0] nxt_pw_m1;
   logic             oe_n_ff, v_n_ff, en_ff;
   logic             nxt_oe_n, nxt_v_n, nxt_en;

   always_comb
   begin
      // Second write word and its lane selects
      nxt_pw_d1 = wr_p2_ff ? dq_i : pw_d1_ff;
      nxt_pw_m1 = wr_p2_ff ? byte_lane_select_n : pw_m1_ff;
      nxt_q_n   = fetched_ff ? (legacy ? r1_ff : r0_ff) : q_n_ff;
      // Drops here once no burst is pending, freeing the bus at once with PLL on; with PLL off the rise before has freed it
      nxt_oe_n  = fetched_ff;
      nxt_v_n   = legacy ? rd_p1_ff : fetched_ff;
      // Copying the rise toggle keeps both halves in phase whenever reset lifts
      nxt_en    = ep_ff;
   end

   always_ff @(negedge clk_link)
   begin
      pw_d1_ff <= nxt_pw_d1;
      pw_m1_ff <= nxt_pw_m1;
      q_n_ff   <= nxt_q_n;
      if (!lrs2_ff)
      begin
         oe_n_ff <= bsd_pkg::RST_OE;
         v_n_ff  <= bsd_pkg::RST_VALID;
         en_ff   <= 1'b0;
      end
      else
      begin
         oe_n_ff <= nxt_oe_n;
         v_n_ff  <= nxt_v_n;
         en_ff   <= nxt_en;
      end
   end

   // DDR output stage: each half cycle shows the register of the edge that opened it.
   // A stopped clock freezes both halves, so the bus holds its state.
   assign dq_o              = clk_link ? q_p_ff : q_n_ff;
   assign dq_oe             = clk_link ? oe_p_ff : oe_n_ff;
   assign output_valid_flag = clk_link ? v_p_ff : v_n_ff;
   assign echo_timing_pos   = ep_ff ^ en_ff;
   assign echo_timing_neg   = !(ep_ff ^ en_ff);
   assign impedance_update  = zq_upd_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // System domain: input clock activity and lock tracking

   localparam int STOP_CW_L = bsd_pkg::STOP_CW;
   localparam int LOCK_CW_L = bsd_pkg::LOCK_CW;

   logic                  ap1_ff, ap2_ff, ap3_ff, fp_ff;
   logic                  an1_ff, an2_ff, an3_ff, fn_ff;
   logic [STOP_CW_L-1:0]  stop_cnt_ff;
   logic [LOCK_CW_L-1:0]  lock_cnt_ff;
   bsd_pkg::bsd_lock_t    lock_st_ff;
   logic                  lock_ff;

   logic                  nxt_ap1, nxt_ap2, nxt_ap3, nxt_fp;
   logic                  nxt_an1, nxt_an2, nxt_an3, nxt_fn;
   logic [STOP_CW_L-1:0]  nxt_stop_cnt;
   logic [LOCK_CW_L-1:0]  nxt_lock_cnt;
   bsd_pkg::bsd_lock_t    nxt_lock_st;
   logic                  nxt_lock;
   logic                  act, stopped;

   always_comb
   begin
      nxt_ap1 = ep_ff;
      nxt_ap2 = ap1_ff;
      nxt_ap3 = ap2_ff;
      nxt_an1 = en_ff;
      nxt_an2 = an1_ff;
      nxt_an3 = an2_ff;
      nxt_fp  = (ap2_ff == ap3_ff) ? ap3_ff : fp_ff;
      nxt_fn  = (an2_ff == an3_ff) ? an3_ff : fn_ff;
      act     = (nxt_fp != fp_ff) || (nxt_fn != fn_ff);
      // Edges arrive every half link period; a gap of STOP_CYC system cycles means a stop
      stopped = (stop_cnt_ff >= STOP_CW_L'(bsd_pkg::STOP_CYC));
      if (act)
      begin
         nxt_stop_cnt = '0;
      end
      else if (!stopped)
      begin
         nxt_stop_cnt = stop_cnt_ff + 1'b1;
      end
      else
      begin
         nxt_stop_cnt = stop_cnt_ff;
      end
      nxt_lock_st  = lock_st_ff;
      nxt_lock_cnt = lock_cnt_ff;
      case (lock_st_ff)
         bsd_pkg::BSD_UNLOCK:
         begin
            nxt_lock_cnt = '0;
            if (act)
            begin
               nxt_lock_st = bsd_pkg::BSD_LOCKING;
            end
         end
         bsd_pkg::BSD_LOCKING:
         begin
            if (stopped)
            begin
               nxt_lock_st = bsd_pkg::BSD_UNLOCK;
            end
            else if (lock_cnt_ff == LOCK_CW_L'(bsd_pkg::LOCK_CYC - 1))
            begin
               nxt_lock_st = bsd_pkg::BSD_LOCKED;
            end
            else
            begin
               nxt_lock_cnt = lock_cnt_ff + 1'b1;
            end
         end
         bsd_pkg::BSD_LOCKED:
         begin
            if (stopped)
            begin
               nxt_lock_st = bsd_pkg::BSD_UNLOCK;
            end
         end
         default:
         begin
            nxt_lock_st = bsd_pkg::BSD_UNLOCK;
         end
      endcase
      nxt_lock = (nxt_lock_st == bsd_pkg::BSD_LOCKED);
   end

   always_ff @(posedge clk_sys)
   begin
      ap1_ff <= nxt_ap1;
      ap2_ff <= nxt_ap2;
      ap3_ff <= nxt_ap3;
      an1_ff <= nxt_an1;
      an2_ff <= nxt_an2;
      an3_ff <= nxt_an3;
      if (!rstn)
      begin
         fp_ff       <= 1'b0;
         fn_ff       <= 1'b0;
         stop_cnt_ff <= '0;
         lock_cnt_ff <= '0;
         lock_st_ff  <= bsd_pkg::BSD_UNLOCK;
         lock_ff     <= 1'b0;
      end
      else
      begin
         fp_ff       <= nxt_fp;
         fn_ff       <= nxt_fn;
         stop_cnt_ff <= nxt_stop_cnt;
         lock_cnt_ff <= nxt_lock_cnt;
         lock_st_ff  <= nxt_lock_st;
         lock_ff     <= nxt_lock;
      end
   end

   assign pll_lock = lock_ff;

endmodule : bsd_port

/* bench/bsd_port_monitor.sv */
// Checker of link timing, echo, impedance and lock behaviour of the SRAM port
`timescale 1ns/100ps
module bsd_port_monitor #(
   parameter int ADDR_W = 4,
   parameter int DW     = 18,
   parameter int LANES  = 2
) (
   input wire logic              clk_sys,
   input wire logic              rstn,
   input wire logic              clk_link,
   input wire logic              access_load_n,
   input wire logic              rw_read,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DW-1:0]     dq_i,
   input wire logic [LANES-1:0]  byte_lane_select_n,
   input wire logic              pll_bypass_n,
   input wire logic [DW-1:0]     dq_o,
   input wire logic              dq_oe,
   input wire logic              output_valid_flag,
   input wire logic              echo_timing_pos,
   input wire logic              echo_timing_neg,
   input wire logic              impedance_update,
   input wire logic              pll_lock
);
   localparam int LOCK_DUE = bsd_pkg::LOCK_CYC + 16;
   logic [11:0] sc_ff, nxt_sc;
   logic [2:0]  rdh_ff, nxt_rdh;
   logic [5:0]  mh_ff, nxt_mh;
   logic [2:0]  up_ff, nxt_up;
   logic [10:0] zg_ff, nxt_zg;
   logic        zs_ff, nxt_zs;
   logic        rd, pll_st, leg_st;
   assign rd = !access_load_n && rw_read;
   // Mode counts as settled only after six equal rises, covering the pin filter
   assign pll_st = pll_bypass_n && (&mh_ff);
   assign leg_st = !pll_bypass_n && !(|mh_ff);
   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_sc = rstn ? sc_ff + {11'h000, sc_ff != 12'hfff} : 12'h000;
   end
   always_ff @(posedge clk_sys) sc_ff <= nxt_sc;
   always_comb
   begin
      nxt_rdh = rstn ? {rdh_ff[1:0], rd} : 3'h0;
      nxt_mh  = {mh_ff[4:0], pll_bypass_n};
      nxt_up  = rstn ? up_ff + {2'h0, up_ff != 3'h7} : 3'h0;
      nxt_zg  = (impedance_update || !rstn) ? 11'h000 : zg_ff + {10'h000, zg_ff != 11'h7ff};
      nxt_zs  = rstn && (zs_ff || impedance_update);
   end
   always_ff @(posedge clk_link)
   begin
      rdh_ff <= nxt_rdh;
      mh_ff  <= nxt_mh;
      up_ff  <= nxt_up;
      zg_ff  <= nxt_zg;
      zs_ff  <= nxt_zs;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_read_lat_pll: assert property (@(posedge clk_link) disable iff (!rstn)
      pll_st && rd && !rdh_ff[0] |-> ##2 !dq_oe ##1 dq_oe) else $error("pll read window misplaced");
   a_read_lat_leg: assert property (@(posedge clk_link) disable iff (!rstn)
      leg_st && rd && !rdh_ff[0] |-> ##1 !dq_oe ##1 dq_oe) else $error("legacy read window misplaced");
   a_valid_lead: assert property (@(negedge clk_link) disable iff (!rstn)
      pll_st && rdh_ff[0] && !rdh_ff[1] |-> ##2 output_valid_flag && !dq_oe) else $error("valid flag not early");
   a_idle_tristate: assert property (@(posedge clk_link) disable iff (!rstn)
      up_ff == 3'h7 && rdh_ff == 3'h0 |-> !dq_oe && !output_valid_flag) else $error("bus driven when idle");
   a_echo_phase: assert property (@(edge clk_link) disable iff (!rstn)
      up_ff == 3'h7 |-> echo_timing_pos == clk_link && echo_timing_neg == !clk_link) else $error("echo off phase");
   a_imp_period: assert property (@(posedge clk_link) disable iff (!rstn)
      impedance_update && zs_ff |-> zg_ff == 11'h3ff ##1 !impedance_update) else $error("impedance period wrong");
   a_lock_early: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(pll_lock) |-> sc_ff >= bsd_pkg::LOCK_CYC) else $error("lock came too early");
   a_lock_due: assert property (@(posedge clk_sys) disable iff (!rstn)
      sc_ff == LOCK_DUE |-> pll_lock) else $error("lock came too late");
   c_pll_read: cover property (@(posedge clk_link) pll_st && rd);
   c_leg_read: cover property (@(posedge clk_link) leg_st && rd);
   c_imp_pulse: cover property (@(posedge clk_link) impedance_update && zs_ff);
endmodule : bsd_port_monitor
bind bsd_port bsd_port_monitor #(.ADDR_W(ADDR_W), .DW(DW), .LANES(LANES)) u_mon (
   .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .access_load_n(access_load_n),
   .rw_read(rw_read), .addr(addr), .dq_i(dq_i), .byte_lane_select_n(byte_lane_select_n),
   .pll_bypass_n(pll_bypass_n), .dq_o(dq_o), .dq_oe(dq_oe), .output_valid_flag(output_valid_flag),
   .echo_timing_pos(echo_timing_pos), .echo_timing_neg(echo_timing_neg),
   .impedance_update(impedance_update), .pll_lock(pll_lock)
);

/* bench/bsd_ctl_model.sv */
// Memory controller model: issues queued commands and drives write data
`timescale 1ns/100ps
module bsd_ctl_model (
   input  wire logic  clk_link,
   output logic       access_load_n = 1'b1,
   output logic       rw_read = 1'b0,
   output logic [3:0] addr = 4'h0,
   output logic [17:0] dq_i = 18'h00000,
   output logic [1:0] byte_lane_select_n = 2'h3
);
   // Op 0 idle, 1 read, 2 write
   typedef struct packed {logic [1:0] op; logic [3:0] a; logic [17:0] d0, d1; logic [1:0] s0, s1;} bsd_cmd_t;
   bsd_cmd_t cq[$];
   bsd_cmd_t nw = '0;
   bsd_cmd_t wd = '0;
   bsd_cmd_t wd2 = '0;
   task automatic push(input logic [1:0] op, input logic [3:0] a, input logic [17:0] d0, input logic [17:0] d1,
                       input logic [1:0] s0, input logic [1:0] s1);
      cq.push_back('{op, a, d0, d1, s0, s1});
   endtask : push
   // Idle lines show the inverse of their last value so stale data never looks valid
   always @(posedge clk_link)
   begin
      wd2 = wd;
      wd = nw;
      nw = (cq.size() > 0) ? cq.pop_front() : '0;
      // Single bank, so one load strobe of our own
      access_load_n      <= (nw.op == 2'h0);
      rw_read            <= (nw.op == 2'h0) ? ~rw_read : nw.op[0];
      addr               <= (nw.op == 2'h0) ? ~addr : nw.a;
      // Second word stands from the rise that took the first until the fall that takes it
      dq_i               <= (wd2.op == 2'h2) ? wd2.d1 : ~dq_i;
      byte_lane_select_n <= (wd2.op == 2'h2) ? wd2.s1 : ~byte_lane_select_n;
   end
   always @(negedge clk_link)
   begin
      // First word settles half a cycle ahead of the rise that takes it
      dq_i               <= (wd.op == 2'h2) ? wd.d0 : ~dq_i;
      byte_lane_select_n <= (wd.op == 2'h2) ? wd.s0 : ~byte_lane_select_n;
   end
endmodule : bsd_ctl_model

/* bench/tb_top.sv */
// Testbench: controller traffic in both latency modes, lock and impedance checks
`timescale 1ns/100ps
module tb_top;
   logic        clk_sys = 1'b0;
   logic        clk_link = 1'b0;
   logic        run_link = 1'b0;
   logic        rstn = 1'b0;
   logic        pll_bypass_n = 1'b1;
   wire logic   access_load_n, rw_read, dq_oe, output_valid_flag, pll_lock;
   wire logic   echo_timing_pos, echo_timing_neg, impedance_update;
   wire logic [3:0]  addr;
   wire logic [17:0] dq_i, dq_o;
   wire logic [1:0]  byte_lane_select_n;
   logic [15:0] lf = 16'he3b1;
   logic [17:0] rm [16][2];
   logic [35:0] eq[$];
   logic [17:0] w0;
   logic [1:0]  last_op = 2'h0;
   logic        pv = 1'b0;
   int          nw = 0;
   int          n_fail = 0;
   int          cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   always
   begin
      wait (run_link);
      #16 clk_link = ~clk_link;
   end
   bsd_port dut (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .access_load_n(access_load_n),
      .rw_read(rw_read), .addr(addr), .dq_i(dq_i), .byte_lane_select_n(byte_lane_select_n),
      .pll_bypass_n(pll_bypass_n), .dq_o(dq_o), .dq_oe(dq_oe), .output_valid_flag(output_valid_flag),
      .echo_timing_pos(echo_timing_pos), .echo_timing_neg(echo_timing_neg),
      .impedance_update(impedance_update), .pll_lock(pll_lock));
   bsd_ctl_model ctl (.clk_link(clk_link), .access_load_n(access_load_n), .rw_read(rw_read), .addr(addr),
      .dq_i(dq_i), .byte_lane_select_n(byte_lane_select_n));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [17:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return {lf[1:0], lf};
   endfunction : rnd
   function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] s);
      return {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
   endfunction : merge
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   // Reference memory is updated at issue time; the device must look the same via posting and bypass
   task automatic op(input logic [1:0] k, input logic [3:0] a, input logic [1:0] m);
      logic [17:0] d0, d1;
      logic [1:0]  s0, s1;
      d0 = rnd();
      d1 = rnd();
      s0 = lf[3:2] & m;
      s1 = lf[5:4] & m;
      if (k == 2'h2 && last_op == 2'h1)
         repeat (3) ctl.push(2'h0, a, d0, d1, s0, s1);
      ctl.push(k, a, d0, d1, s0, s1);
      if (k == 2'h2)
      begin
         rm[a][0] = merge(rm[a][0], d0, s0);
         rm[a][1] = merge(rm[a][1], d1, s1);
      end
      if (k == 2'h1)
         eq.push_back({rm[a][0], rm[a][1]});
      if (k != 2'h0)
         last_op = k;
   endtask : op
   task automatic drain();
      int i;
      for (i = 0; i < 600 && (eq.size() > 0 || ctl.cq.size() > 0); i++)
         @(posedge clk_link);
      if (i == 600)
      begin
         check(36'h1, 36'h0);
         stop_test();
      end
      else
         repeat (8) @(posedge clk_link);
   endtask : drain
   ////////////////////////////////////////////////////////////////////////////////
   // Words are taken 4 ns into each 16 ns phase while the enable is high; the first of each pair must follow a set valid flag
   always @(clk_link)
   begin
      #4;
      if (dq_oe === 1'b1)
      begin
         if (nw == 0)
            check({35'h0, pv}, 36'h1);
         if (nw == 0)
            w0 = dq_o;
         else if (eq.size() == 0)
            check({w0, dq_o}, ~{w0, dq_o});
         else
            check({w0, dq_o}, eq.pop_front());
         nw = 1 - nw;
      end
      pv = output_valid_flag;
   end
   initial
   begin
      #0.3 run_link = 1'b1;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 3000 && pll_lock !== 1'b1; i++)
         @(posedge clk_sys);
      check({35'h0, pll_lock}, 36'h1);
      if (pll_lock !== 1'b1)
         stop_test();
      for (int m = 0; m < 2; m++)
      begin
         @(posedge clk_link);
         pll_bypass_n <= (m == 0);
         repeat (10) @(posedge clk_link);
         for (int a = 0; a < 16; a++)
            op(2'h2, a[3:0], 2'h0);
         for (int a = 0; a < 16; a++)
            op(2'h1, a[3:0], 2'h0);
         for (int a = 0; a < 4; a++)
         begin
            op(2'h2, a[3:0], 2'h3);
            op(2'h1, a[3:0], 2'h3);
         end
         for (int i = 0; i < 120; i++)
            op(lf[6] ? 2'h1 : (lf[7] ? 2'h2 : 2'h0), {2'h0, lf[9:8]}, 2'h3);
         drain();
      end
      pll_bypass_n <= 1'b1;
      repeat (2200) @(posedge clk_link);
      @(posedge clk_sys);
      run_link = 1'b0;
      repeat (20) @(posedge clk_sys);
      check({35'h0, pll_lock}, 36'h0);
      run_link = 1'b1;
      stop_test();
   end
endmodule : tb_top
